// ===== src/irq_ctl.sv
// Interrupt latch controller: pending latches, enables, priority, accept.
// Assumes the CPU sequencer raises accept_req at instruction end and
// waits for a grant; registers are on a plain 8-bit strobe port.
//
// Function
// - A source request sets its pending latch; enabled ones request service.
// - Accepting an interrupt clears that source's pending latch.
// - Reset clears every pending latch.
// - Writing 0 clears a latch; writing 1 leaves it unchanged.
// - Software reads pending latches, 1 meaning pending.
// - No latch for software or undefined-opcode; levels 2 to 15 latched.
// - Latches at 003CH low and 003DH high; bits 1 and 0 unused.
// - Enable register at 003AH/003BH, readable and writable except bits 3 to 1, which stay 0.
// - Master enable bit 0; source enables bits 15 to 4.
// - Master enable 0 blocks every maskable interrupt.
// - Maskable needs master and own enable; external 0 needs pin enable.
// - Accept saves master enable then clears it; return restores it.
// - Reset clears master enable.
// - Reset clears all source enables.
// - Software, undefined, trap and watchdog ignore the enable register.
// - Fixed priority among maskables; vectors FFF6 down to FFE0.
// - Non-maskable vectors FFFC, FFFA, FFF8; reset FFFE.
// - Level 15 shared by converter-done and external 2 via selector.
// - Trap and watchdog latch only once their output select is 0.
// - Requests from an unselected shared source are never latched.
// - Acceptance lasts 8 machine cycles after the instruction ends.
// - Acceptance pushes status, PC high, PC low; stack drops by 3.
`timescale 1ns/1ps
`default_nettype none
module irq_ctl #(
	parameter int ACCEPT_LEN = irq_ctl_pkg::ACCEPT_CYCLES
) (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// Register port
	input  wire irq_ctl_pkg::reg_req_t req,
	output var  logic [7:0]           rdata_q,
	// Peripheral requests as one-cycle pulses, with ext 0 pin enable and output selects
	input  wire logic [15:4]          src_irq,
	input  wire logic                 ext_irq2,
	input  wire logic                 ext0_pin_enable,
	input  wire logic                 address_trap_irq,
	input  wire logic                 watchdog_irq,
	input  wire logic                 trap_output_select,
	input  wire logic                 watchdog_output_select,
	// CPU sequencer
	input  wire logic                 software_instruction_irq,
	input  wire logic                 undefined_opcode_irq,
	input  wire logic                 accept_req,
	input  wire logic                 return_instr,
	input  wire logic                 return_flag,
	output var  logic                 irq_pending_q,
	output var  irq_ctl_pkg::grant_t  grant_q,
	output var  logic                 saved_master_q,
	output var  logic                 busy_q,
	output var  logic [1:0]           push_index_q,
	output var  logic                 push_strobe_q
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {IDLE, ACCEPT} seq_t;
	seq_t        state_q;
	logic [15:0] pending_q;
	logic [15:0] enable_q;
	logic        selector_q;
	logic [3:0]  count_q;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [15:0] cand;
	logic        nm_soft;
	logic        pick_any;
	logic [3:0]  pick_level;
	logic [15:0] pick_vector;
	logic        start;

	// ----------------------------------------------------------------
	// Request capture
	// ----------------------------------------------------------------
	always_comb begin
		set_vec = irq_ctl_pkg::ZERO16;
		set_vec[15:4] = src_irq;
		// Unselected shared source never reaches the latch
		set_vec[irq_ctl_pkg::LAST_LEVEL] = selector_q ? ext_irq2
			: src_irq[irq_ctl_pkg::LAST_LEVEL];
		set_vec[irq_ctl_pkg::TRAP_LEVEL] = address_trap_irq
			& ~trap_output_select;
		set_vec[irq_ctl_pkg::WDOG_LEVEL] = watchdog_irq
			& ~watchdog_output_select;
		set_vec = set_vec & irq_ctl_pkg::LATCH_MASK;
	end

	// Software clear: zero bits of a write clear, one bits keep
	always_comb begin
		clr_vec = irq_ctl_pkg::ZERO16;
		if (req.wr && req.addr == irq_ctl_pkg::ADDR_PENDING_LO)
			clr_vec[7:0] = ~req.wdata;
		if (req.wr && req.addr == irq_ctl_pkg::ADDR_PENDING_HI)
			clr_vec[15:8] = ~req.wdata;
		if (start && !nm_soft)
			clr_vec[pick_level] = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			pending_q <= irq_ctl_pkg::ZERO16;
		else
			// Set wins so a request racing a clear is kept
			pending_q <= ((pending_q & ~clr_vec) | set_vec)
				& irq_ctl_pkg::LATCH_MASK;
	end

	// ----------------------------------------------------------------
	// Enable register and selector
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			enable_q <= irq_ctl_pkg::ZERO16;
		end else begin
			if (req.wr && req.addr == irq_ctl_pkg::ADDR_ENABLE_LO)
				enable_q[7:0] <= req.wdata
					& irq_ctl_pkg::ENABLE_MASK[7:0]
					| (req.wdata & 8'h01);
			if (req.wr && req.addr == irq_ctl_pkg::ADDR_ENABLE_HI)
				enable_q[15:8] <= req.wdata;
			if (start)
				enable_q[irq_ctl_pkg::MASTER_BIT] <= 1'b0;
			else if (return_instr)
				enable_q[irq_ctl_pkg::MASTER_BIT] <= return_flag;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			selector_q <= 1'b0;
		else if (req.wr && req.addr == irq_ctl_pkg::ADDR_SELECTOR)
			selector_q <= req.wdata[irq_ctl_pkg::SEL_BIT];
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			rdata_q <= irq_ctl_pkg::ZERO8;
		else if (req.rd) begin
			unique case (req.addr)
				irq_ctl_pkg::ADDR_ENABLE_LO:  rdata_q <= enable_q[7:0];
				irq_ctl_pkg::ADDR_ENABLE_HI:  rdata_q <= enable_q[15:8];
				irq_ctl_pkg::ADDR_PENDING_LO: rdata_q <= pending_q[7:0];
				irq_ctl_pkg::ADDR_PENDING_HI: rdata_q <= pending_q[15:8];
				irq_ctl_pkg::ADDR_SELECTOR:   rdata_q <= {7'h00, selector_q};
				default:                      rdata_q <= irq_ctl_pkg::ZERO8;
			endcase
		end else
			rdata_q <= irq_ctl_pkg::ZERO8;
	end

	// ----------------------------------------------------------------
	// Priority resolution
	// ----------------------------------------------------------------
	always_comb begin
		cand = pending_q;
		// Maskable levels need master, own flag, and pin enable for ext 0
		for (int i = irq_ctl_pkg::FIRST_MASK; i <= irq_ctl_pkg::LAST_LEVEL;
				i++) begin
			cand[i] = pending_q[i] & enable_q[i]
				& enable_q[irq_ctl_pkg::MASTER_BIT];
		end
		cand[irq_ctl_pkg::EXT0_LEVEL] = cand[irq_ctl_pkg::EXT0_LEVEL]
			& ext0_pin_enable;
	end

	irq_pick #(
		.LEVELS (16)
	) u_pick (
		.cand   (cand),
		.any    (pick_any),
		.level  (pick_level),
		.vector (pick_vector)
	);

	// Software and undefined-opcode bypass all enables
	assign nm_soft = software_instruction_irq | undefined_opcode_irq;
	assign start   = (state_q == IDLE) && accept_req
		&& (nm_soft || pick_any);

	// ----------------------------------------------------------------
	// Acceptance sequence
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q        <= IDLE;
			count_q        <= 4'h0;
			grant_q        <= '0;
			saved_master_q <= 1'b0;
		end else begin
			grant_q.take <= 1'b0;
			unique case (state_q)
				IDLE: begin
					if (start) begin
						state_q        <= ACCEPT;
						count_q        <= 4'h0;
						saved_master_q <= enable_q[irq_ctl_pkg::MASTER_BIT];
						grant_q.take   <= 1'b1;
						grant_q.level  <= nm_soft ? 4'h0 : pick_level;
						grant_q.vector <= nm_soft ? irq_ctl_pkg::VEC_SOFT
							: pick_vector;
					end
				end
				ACCEPT: begin
					count_q <= 4'(count_q + 4'h1);
					if (count_q == 4'(ACCEPT_LEN - 1))
						state_q <= IDLE;
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	// Push strobes in cycles 1..3: status, PC high, PC low
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			push_strobe_q <= 1'b0;
			push_index_q  <= 2'h0;
			busy_q        <= 1'b0;
			irq_pending_q <= 1'b0;
		end else begin
			busy_q        <= start || (state_q == ACCEPT
				&& count_q != 4'(ACCEPT_LEN - 1));
			push_strobe_q <= state_q == ACCEPT
				&& count_q < 4'(irq_ctl_pkg::STACK_BYTES);
			push_index_q  <= count_q[1:0];
			irq_pending_q <= pick_any;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_reset_clear: assert property (@(posedge ref_clk)
		!rst_n |=> pending_q == irq_ctl_pkg::ZERO16 && enable_q == 16'h0000)
		else $error("reset left latches or enables set");
	chk_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		set_vec[5] |=> pending_q[5])
		else $error("request lost");
	chk_master_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!enable_q[0] |-> cand[15:4] == 12'h000)
		else $error("maskable candidate with master off");
	chk_accept_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start |=> (state_q == ACCEPT) [*8] ##1 state_q == IDLE)
		else $error("acceptance length wrong");
	chk_master_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start |=> !enable_q[0] && saved_master_q == $past(enable_q[0]))
		else $error("master not saved and cleared");
	chk_latch_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start && !nm_soft && set_vec[pick_level] == 1'b0
		|=> !pending_q[$past(pick_level)])
		else $error("accepted latch not cleared");
	chk_no_sw_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		set_vec == 16'h0000 |=> (pending_q & ~$past(pending_q)) == 16'h0000)
		else $error("latch set without request");
	chk_unused_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pending_q[1:0] == 2'b00)
		else $error("unused latch bits set");
	chk_push_three: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start |=> ##1 push_strobe_q [*3] ##1 !push_strobe_q)
		else $error("push strobes wrong");
	chk_take_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		grant_q.take |=> !grant_q.take)
		else $error("grant held longer than one cycle");
	chk_set_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		set_vec[9] |=> pending_q[9])
		else $error("request did not set its latch");
	chk_unselected: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!selector_q && !src_irq[15] && !pending_q[15] |=> !pending_q[15])
		else $error("unselected shared source latched");
	chk_trap_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		trap_output_select && !pending_q[2] |=> !pending_q[2])
		else $error("trap latched while routed to reset");
	chk_wdog_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		watchdog_output_select && !pending_q[3] |=> !pending_q[3])
		else $error("watchdog latched while routed to reset");
	chk_enable_gaps: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable_q[3:1] == 3'b000)
		else $error("unused enable bits set");
	chk_soft_vector: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start && nm_soft |=> grant_q.vector == irq_ctl_pkg::VEC_SOFT)
		else $error("software vector wrong");
	chk_ret_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
		return_instr && !start |=> enable_q[0] == $past(return_flag))
		else $error("return did not restore master");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	cov_return:      cover property (@(posedge ref_clk) return_instr && return_flag);
	cov_mask_accept: cover property (@(posedge ref_clk) start && !nm_soft);
	cov_soft_accept: cover property (@(posedge ref_clk) start && nm_soft);
	cov_shared_ext:  cover property (@(posedge ref_clk) selector_q && ext_irq2);
endmodule : irq_ctl
`default_nettype wire

// ===== src/irq_ctl_pkg.sv
// Constants and types for the prioritised interrupt latch controller.
// Assumes an 8-bit register port with byte addresses in the SFR space.
package irq_ctl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_ENABLE_LO  = 8'h3A;
	localparam logic [7:0] ADDR_ENABLE_HI  = 8'h3B;
	localparam logic [7:0] ADDR_PENDING_LO = 8'h3C;
	localparam logic [7:0] ADDR_PENDING_HI = 8'h3D;
	localparam logic [7:0] ADDR_SELECTOR   = 8'h3E;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int MASTER_BIT  = 0;
	localparam int TRAP_LEVEL  = 2;
	localparam int WDOG_LEVEL  = 3;
	localparam int EXT0_LEVEL  = 4;
	localparam int FIRST_MASK  = 4;
	localparam int LAST_LEVEL  = 15;
	localparam int SEL_BIT     = 0;
	localparam logic [15:0] LATCH_MASK  = 16'hFFFC;
	localparam logic [15:0] ENABLE_MASK = 16'hFFF0;
	localparam logic [15:0] ZERO16      = 16'h0000;
	localparam logic [7:0]  ZERO8       = 8'h00;

	// ----------------------------------------------------------------
	// Vectors
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_SOFT  = 16'hFFFC;
	localparam logic [15:0] VEC_TRAP  = 16'hFFFA;
	localparam logic [15:0] VEC_WDOG  = 16'hFFF8;
	localparam logic [15:0] VEC_BASE  = 16'hFFF6;
	localparam logic [15:0] VEC_STEP  = 16'h0002;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int ACCEPT_CYCLES = 8;
	localparam int STACK_BYTES   = 3;

	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Answer to the CPU sequencer
	typedef struct packed {
		logic        take;
		logic [3:0]  level;
		logic [15:0] vector;
	} grant_t;

endpackage : irq_ctl_pkg

// ===== src/irq_pick.sv
// Fixed-priority picker over the acceptable levels.
// Assumes the caller has already gated levels by enables.
`timescale 1ns/1ps
`default_nettype none
module irq_pick #(
	parameter int LEVELS = 16
) (
	// Candidates
	input  wire logic [LEVELS-1:0] cand,
	// Result
	output var  logic              any,
	output var  logic [3:0]        level,
	output var  logic [15:0]       vector
);
	// Lower level number wins; scan from the top so the last hit stands
	always_comb begin
		any    = 1'b0;
		level  = 4'h0;
		vector = irq_ctl_pkg::VEC_RESET;
		for (int i = LEVELS - 1; i >= irq_ctl_pkg::TRAP_LEVEL; i--) begin
			if (cand[i]) begin
				any   = 1'b1;
				level = 4'(i);
				if (i == irq_ctl_pkg::TRAP_LEVEL)
					vector = irq_ctl_pkg::VEC_TRAP;
				else if (i == irq_ctl_pkg::WDOG_LEVEL)
					vector = irq_ctl_pkg::VEC_WDOG;
				else
					vector = 16'(irq_ctl_pkg::VEC_BASE
						- 16'(i - irq_ctl_pkg::FIRST_MASK)
						* irq_ctl_pkg::VEC_STEP);
			end
		end
	end
endmodule : irq_pick
`default_nettype wire

// ===== test/cpu_seq_model.sv
// CPU sequencer model: raises accept at instruction end, returns.
// Assumes one ref_clk domain and a controller that never stalls.
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model (
	// Clock
	input  wire logic                ref_clk,
	// Answers from the controller
	input  wire irq_ctl_pkg::grant_t grant_q,
	input  wire logic                busy_q,
	input  wire logic [1:0]          push_index_q,
	input  wire logic                push_strobe_q,
	// Requests to the controller
	output var  logic                accept_req,
	output var  logic                return_instr,
	output var  logic                return_flag,
	output var  logic                software_instruction_irq,
	output var  logic                undefined_opcode_irq
);
	initial begin
		accept_req = 1'b0;
		return_instr = 1'b0;
		return_flag = 1'b0;
		software_instruction_irq = 1'b0;
		undefined_opcode_irq = 1'b0;
	end

	// One acceptance, then twelve cycles of watching the answer
	task automatic accept(input logic sw, input logic ud,
		output logic [15:0] vec, output logic [3:0] lvl,
		output int took, output int pushes, output int busy_n,
		output int bad);
		took = 0;
		pushes = 0;
		busy_n = 0;
		bad = 0;
		vec = 16'h0000;
		lvl = 4'h0;
		@(posedge ref_clk);
		accept_req <= 1'b1;
		software_instruction_irq <= sw;
		undefined_opcode_irq <= ud;
		@(posedge ref_clk);
		accept_req <= 1'b0;
		software_instruction_irq <= 1'b0;
		undefined_opcode_irq <= 1'b0;
		repeat (12) begin
			#1;
			if (grant_q.take === 1'b1) begin
				took++;
				vec = grant_q.vector;
				lvl = grant_q.level;
			end
			// Status, PC high, PC low in that order
			if (push_strobe_q === 1'b1) begin
				if (push_index_q !== 2'(pushes)) bad++;
				pushes++;
			end
			if (busy_q === 1'b1) busy_n++;
			@(posedge ref_clk);
		end
	endtask : accept

	task automatic ret(input logic f);
		@(posedge ref_clk);
		return_instr <= 1'b1;
		return_flag <= f;
		@(posedge ref_clk);
		return_instr <= 1'b0;
	endtask : ret
endmodule : cpu_seq_model
`default_nettype wire

// ===== test/irq_ctl_tb.sv
// Self-checking bench for the interrupt latch controller.
// Assumes the sequencer model beside it and an 8 ns clock.
`timescale 1ns/1ps
`default_nettype none
module irq_ctl_tb;
	logic                 ref_clk, rst_n, ext_irq2, ext0_pin_enable;
	logic                 address_trap_irq, watchdog_irq;
	logic                 trap_output_select, watchdog_output_select;
	logic                 accept_req, return_instr, return_flag;
	logic                 software_instruction_irq, undefined_opcode_irq;
	logic                 irq_pending_q, saved_master_q, busy_q;
	logic                 push_strobe_q;
	logic [1:0]           push_index_q;
	logic [7:0]           rdata_q;
	logic [15:4]          src_irq;
	logic [15:0]          vec, pend;
	logic [3:0]           lvl;
	irq_ctl_pkg::reg_req_t req;
	irq_ctl_pkg::grant_t  grant_q;
	int                   took, pushes, busy_n, bad, n, cyc_n;
	int                   checks, fail_count;
	logic [15:0]          nmv [4] = '{16'hFFFC, 16'hFFFC, 16'hFFFA, 16'hFFF8};

	irq_ctl #(.ACCEPT_LEN(8)) irq_ctl_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.req(req), .rdata_q(rdata_q), .src_irq(src_irq),
		.ext_irq2(ext_irq2), .ext0_pin_enable(ext0_pin_enable),
		.address_trap_irq(address_trap_irq), .watchdog_irq(watchdog_irq),
		.trap_output_select(trap_output_select),
		.watchdog_output_select(watchdog_output_select),
		.software_instruction_irq(software_instruction_irq),
		.undefined_opcode_irq(undefined_opcode_irq),
		.accept_req(accept_req), .return_instr(return_instr),
		.return_flag(return_flag), .irq_pending_q(irq_pending_q),
		.grant_q(grant_q), .saved_master_q(saved_master_q),
		.busy_q(busy_q), .push_index_q(push_index_q),
		.push_strobe_q(push_strobe_q));

	cpu_seq_model cpu_seq_model_i (.ref_clk(ref_clk), .grant_q(grant_q),
		.busy_q(busy_q), .push_index_q(push_index_q),
		.push_strobe_q(push_strobe_q), .accept_req(accept_req),
		.return_instr(return_instr), .return_flag(return_flag),
		.software_instruction_irq(software_instruction_irq),
		.undefined_opcode_irq(undefined_opcode_irq));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic results;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// Generous ceiling: the whole run needs under 1500 cycles
	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 6000) begin
			fail_count++;
			results();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One cycle of register write and peripheral pulses together
	task automatic cyc(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [15:4] s, input logic e2,
		input logic t, input logic wd);
		@(posedge ref_clk);
		req <= '{wr: w, rd: 1'b0, addr: a, wdata: d};
		src_irq <= s;
		ext_irq2 <= e2;
		address_trap_irq <= t;
		watchdog_irq <= wd;
		@(posedge ref_clk);
		req <= '0;
		src_irq <= '0;
		{ext_irq2, address_trap_irq, watchdog_irq} <= 3'b000;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1'b1, a, d, 12'h000, 1'b0, 1'b0, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req <= '0;
		#1 chk({8'h00, rdata_q}, {8'h00, e});
	endtask : rd

	task automatic acc(input logic sw, input logic ud);
		cpu_seq_model_i.accept(sw, ud, vec, lvl, took, pushes, busy_n, bad);
	endtask : acc

	initial begin
		{rst_n, ext_irq2, ext0_pin_enable, address_trap_irq} = 4'h0;
		{trap_output_select, watchdog_output_select} = 2'b11;
		{watchdog_irq, req, src_irq} = '0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (n = 8'h3A; n <= 8'h3E; n++) rd(8'(n), 8'h00);
		rd(8'h40, 8'h00);
		$display("test reset done");
		wr(8'h3A, 8'hFE);
		wr(8'h3B, 8'hFF);
		rd(8'h3A, 8'hF0);
		rd(8'h3B, 8'hFF);
		cyc(1'b0, 8'h00, 8'h00, 12'hFFF, 1'b0, 1'b0, 1'b0);
		rd(8'h3C, 8'hF0);
		rd(8'h3D, 8'hFF);
		chk(16'(irq_pending_q), 16'h0000);
		acc(1'b0, 1'b0);
		chk(16'(took), 16'h0000);
		pend = 16'hFFF0;
		for (int i = 0; i < 12; i++) begin
			n = (i < 11) ? i + 5 : 4;
			@(posedge ref_clk);
			ext0_pin_enable <= (i == 11);
			wr(8'h3A, 8'hF1);
			repeat (2) @(posedge ref_clk);
			#1 chk(16'(irq_pending_q), 16'h0001);
			acc(1'b0, 1'b0);
			pend[n] = 1'b0;
			chk(16'(took), 16'h0001);
			chk(16'(lvl), 16'(n));
			chk(vec, 16'hFFF6 - 16'(2 * (n - 4)));
			chk(16'(pushes), 16'h0003);
			chk(16'(bad), 16'h0000);
			chk(16'(busy_n), 16'h0008);
			chk(16'(saved_master_q), 16'h0001);
			rd(8'h3A, 8'hF0);
			rd(8'h3C, pend[7:0]);
			rd(8'h3D, pend[15:8]);
		end
		cpu_seq_model_i.ret(1'b1);
		rd(8'h3A, 8'hF1);
		cpu_seq_model_i.ret(1'b0);
		rd(8'h3A, 8'hF0);
		$display("test priority done");
		cyc(1'b0, 8'h00, 8'h00, 12'h000, 1'b1, 1'b0, 1'b0);
		rd(8'h3D, 8'h00);
		cyc(1'b0, 8'h00, 8'h00, 12'h800, 1'b0, 1'b0, 1'b0);
		rd(8'h3D, 8'h80);
		wr(8'h3D, 8'h7F);
		wr(8'h3E, 8'h01);
		rd(8'h3E, 8'h01);
		cyc(1'b0, 8'h00, 8'h00, 12'h800, 1'b0, 1'b0, 1'b0);
		rd(8'h3D, 8'h00);
		cyc(1'b0, 8'h00, 8'h00, 12'h000, 1'b1, 1'b0, 1'b0);
		rd(8'h3D, 8'h80);
		wr(8'h3A, 8'hF1);
		acc(1'b0, 1'b0);
		chk(vec, 16'hFFE0);
		$display("test shared level done");
		cyc(1'b0, 8'h00, 8'h00, 12'h000, 1'b0, 1'b1, 1'b1);
		rd(8'h3C, 8'h00);
		@(posedge ref_clk);
		{trap_output_select, watchdog_output_select} <= 2'b00;
		for (int i = 0; i < 4; i++) begin
			if (i >= 2) cyc(1'b0, 8'h00, 8'h00, 12'h000, 1'b0, i == 2, i == 3);
			acc(i == 0, i == 1);
			chk(vec, nmv[i]);
			rd(8'h3C, 8'h00);
		end
		$display("test non-maskable done");
		cyc(1'b0, 8'h00, 8'h00, 12'hFFF, 1'b0, 1'b1, 1'b1);
		rd(8'h3C, 8'hFC);
		wr(8'h3C, 8'h0F);
		rd(8'h3C, 8'h0C);
		wr(8'h3D, 8'h5A);
		wr(8'h3D, 8'hFF);
		rd(8'h3D, 8'h5A);
		cyc(1'b1, 8'h3C, 8'h0C, 12'h002, 1'b0, 1'b0, 1'b0);
		rd(8'h3C, 8'h2C);
		$display("test latch writes done");
		results();
	end
endmodule : irq_ctl_tb
`default_nettype wire
